//--- design/rtc_pkg.sv
// Purpose: Shared constants of the clock event logic.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Tick counts are in 32.768 kHz oscillator ticks.
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1  = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_CTRL3  = 8'h08;
  localparam logic [7:0] OFS_CYCSEL = 8'h0C;
  localparam logic [7:0] OFS_TMRSEL = 8'h10;
  localparam logic [7:0] OFS_ALARM  = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CLOCK_RUN   = 0;
  localparam int BIT_ALARM_ARM   = 1;
  localparam int BIT_TIMER_RST   = 2;
  localparam int BIT_BANK        = 3;
  localparam int BIT_CYCLIC_FLAG = 0;
  localparam int BIT_ALARM_FLAG  = 1;
  localparam int BIT_CARRY_BUSY  = 2;
  localparam int BIT_OSC_STOP    = 3;
  localparam int BIT_TEST_A      = 0;
  localparam int BIT_TEST_B      = 1;
  localparam int BIT_CLOCK_RESET = 2;
  localparam int BIT_SEL_MSB     = 3;
  localparam int POS_ALARM_HOUR  = 8;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic       RST_CLOCK_RUN = 1'b1;
  localparam logic       RST_OSC_STOP  = 1'b1;
  localparam logic [3:0] RST_SEL       = 4'h0;

  // ----------------------------------------------------------------
  // Periods in oscillator ticks
  // ----------------------------------------------------------------
  localparam int          PER_W       = 21;
  localparam logic [20:0] CYC_T_488US = 21'h000010;
  localparam logic [20:0] CYC_T_977US = 21'h000020;
  localparam logic [20:0] CYC_T_7MS   = 21'h000100;
  localparam logic [20:0] CYC_T_62MS  = 21'h000800;
  localparam logic [20:0] CYC_T_1S    = 21'h008000;
  localparam logic [20:0] CYC_T_60S   = 21'h1E0000;
  localparam logic [20:0] TMR_T_BASE  = 21'h000010;

  // ----------------------------------------------------------------
  // Output pulse widths
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int PULSE_WIDTH_NS = 30500;
  localparam int PULSE_CYCLES   = PULSE_WIDTH_NS / CLK_PERIOD_NS;
  localparam int PULSE_W        = 10;

endpackage

//--- design/rtc_period_cnt.sv
// Purpose: Tick counter that pulses once per programmed period.
// Assumes: tick is a one-cycle strobe on ref_clk.
// Notes:   A zero period never pulses.
`timescale 1ns/1ns
module rtc_period_cnt
  import rtc_pkg::*;
#(
  parameter int W = PER_W
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  // Result
  output      logic         pulse
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } rtc_cnt_state_t;

  rtc_cnt_state_t st_reg;
  rtc_cnt_state_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (restart || period == '0) begin
      st_next.cnt = '0;
    end else if (run && tick) begin
      if (st_reg.cnt >= period - W'(1)) begin
        st_next.cnt   = '0;
        st_next.pulse = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.pulse;

endmodule

//--- design/rtc_event_core.sv
// Purpose: Alarm, cyclic interrupt, timer and oscillator-stop logic.
// Assumes: oscTick is a ref_clk strobe at the crystal rate; the time
//          counter supplies the current minute and hour in BCD.
// Notes:   Registers sit on APB with zero wait states.
//
// Function
// - Alarm match on minute and hour pulls irq.
// - Irq pin is OR of both sources.
// - Alarm flag reads inverse of pin.
// - Cyclic flag reads inverse of pin.
// - Six cyclic periods from divider chain.
// - Cyclic output in pulse or level mode.
// - Writing zero clears level-mode cyclic request.
// - Zero cycle selection stops cyclic interrupts.
// - Interrupts work whatever chip enable is.
// - Timer pulses output every selected interval.
// - Timer restart bit restarts timer counter.
// - Timer halts while chip enable low.
// - Oscillator stop forces timer select msb zero.
// - Timer restart during pulse ends pulse.
// - Oscillator stop sets the stop flag.
// - Stop flag is one after power-up.
// - Stop flag sticks until host clears it.
// - Test and clock-reset bits set busy.
// - Cycle select msb one selects level mode.
// - Chip enable low forces clock run on.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
module rtc_event_core
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Pins
  input  wire logic        chipEnable,
  input  wire logic        oscAlive,
  // Time counter side
  input  wire logic        oscTick,
  input  wire logic        carryActive,
  input  wire logic [6:0]  curMinute,
  input  wire logic [5:0]  curHour,
  output      logic        clockRun,
  // Interrupt pin, open drain
  output      logic        irqOutNOut,
  output      logic        irqOutNOe,
  // Timer output pin
  output      logic        periodicPulseOutN
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               ceMeta;
    logic               ceSync;
    logic               oscMeta;
    logic               oscSync;
    logic               clockRun;
    logic               alarmArm;
    logic               bankSel;
    logic               testA;
    logic               testB;
    logic               clkRst;
    logic               alarmFlag;
    logic               matchPrev;
    logic               cyclicReq;
    logic               oscStopFlag;
    logic               carryBusy;
    logic [3:0]         cycleSel;
    logic [3:0]         timerSel;
    logic [6:0]         alarmMin;
    logic [5:0]         alarmHour;
    logic [PULSE_W-1:0] cycPulseCnt;
    logic [PULSE_W-1:0] tmrPulseCnt;
    logic               irqPending;
    logic               timerOut;
    logic [31:0]        prdata;
    logic               slvErr;
  } rtc_state_t;

  rtc_state_t st_reg;
  rtc_state_t st_next;

  logic [PER_W-1:0] cycPeriod;
  logic [PER_W-1:0] tmrPeriod;
  logic             cycPulse;
  logic             tmrPulse;
  logic             timerRestart;
  logic             cycRestart;
  logic             wrEn;
  logic             rdSetup;
  logic             mapped;
  logic             alarmMatch;
  logic [31:0]      rdData;

  // ----------------------------------------------------------------
  // Period selection
  // ----------------------------------------------------------------
  always_comb begin
    unique case (st_reg.cycleSel[2:0])
      3'h1:    cycPeriod = CYC_T_488US;
      3'h2:    cycPeriod = CYC_T_977US;
      3'h3:    cycPeriod = CYC_T_7MS;
      3'h4:    cycPeriod = CYC_T_62MS;
      3'h5:    cycPeriod = CYC_T_1S;
      3'h6:    cycPeriod = CYC_T_60S;
      default: cycPeriod = '0;
    endcase
  end

  // Each timer step is four times the previous one.
  assign tmrPeriod = PER_W'(TMR_T_BASE << (2 * st_reg.timerSel[2:0]));

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Chip enable low shuts the bus out, as on the parallel pins.
  assign wrEn    = psel && penable && pwrite && st_reg.ceSync;
  assign rdSetup = psel && !penable;
  assign timerRestart = wrEn && paddr == OFS_CTRL1
                        && pwdata[BIT_TIMER_RST];
  assign cycRestart = wrEn && paddr == OFS_CYCSEL;

  always_comb begin
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL1: begin
        rdData[BIT_CLOCK_RUN] = st_reg.clockRun;
        rdData[BIT_ALARM_ARM] = st_reg.alarmArm;
        rdData[BIT_BANK]      = st_reg.bankSel;
      end
      OFS_CTRL2: begin
        rdData[BIT_CYCLIC_FLAG] = st_reg.cyclicReq;
        rdData[BIT_ALARM_FLAG]  = st_reg.alarmFlag;
        rdData[BIT_CARRY_BUSY]  = st_reg.carryBusy || carryActive;
        rdData[BIT_OSC_STOP]    = st_reg.oscStopFlag;
      end
      OFS_CTRL3: begin
        rdData[BIT_TEST_A]      = st_reg.testA;
        rdData[BIT_TEST_B]      = st_reg.testB;
        rdData[BIT_CLOCK_RESET] = st_reg.clkRst;
      end
      OFS_CYCSEL: rdData[3:0] = st_reg.cycleSel;
      OFS_TMRSEL: rdData[3:0] = st_reg.timerSel;
      OFS_ALARM: begin
        rdData[6:0] = st_reg.alarmMin;
        rdData[POS_ALARM_HOUR +: 6] = st_reg.alarmHour;
      end
      default: mapped = 1'b0;
    endcase
    if (!st_reg.ceSync) begin
      rdData = 32'h0000_0000;
    end
  end

  // The host arms only after loading a valid time, so no stale match.
  assign alarmMatch = st_reg.alarmArm
                      && st_reg.alarmMin == curMinute
                      && st_reg.alarmHour == curHour;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // Pins pass two flops before use.
    st_next.ceMeta  = chipEnable;
    st_next.ceSync  = st_reg.ceMeta;
    st_next.oscMeta = oscAlive;
    st_next.oscSync = st_reg.oscMeta;

    // Read data is captured in the setup cycle.
    if (rdSetup) begin
      st_next.prdata = rdData;
      st_next.slvErr = !mapped;
    end

    // Register writes.
    if (wrEn) begin
      unique case (paddr)
        OFS_CTRL1: begin
          st_next.clockRun = pwdata[BIT_CLOCK_RUN];
          st_next.alarmArm = pwdata[BIT_ALARM_ARM];
          st_next.bankSel  = pwdata[BIT_BANK];
        end
        OFS_CTRL2: begin
          if (!pwdata[BIT_CYCLIC_FLAG] && st_reg.cycleSel[BIT_SEL_MSB]) begin
            st_next.cyclicReq = 1'b0;
          end
          if (!pwdata[BIT_ALARM_FLAG]) begin
            st_next.alarmFlag = 1'b0;
          end
          if (!pwdata[BIT_OSC_STOP]) begin
            st_next.oscStopFlag = 1'b0;
          end
        end
        OFS_CTRL3: begin
          st_next.testA  = pwdata[BIT_TEST_A];
          st_next.testB  = pwdata[BIT_TEST_B];
          st_next.clkRst = pwdata[BIT_CLOCK_RESET];
          if (pwdata[BIT_TEST_A] && pwdata[BIT_TEST_B]
              && pwdata[BIT_CLOCK_RESET]) begin
            st_next.carryBusy = 1'b1;
          end
        end
        OFS_CYCSEL: begin
          st_next.cycleSel = pwdata[3:0];
          if (pwdata[2:0] == 3'h0) begin
            st_next.cyclicReq   = 1'b0;
            st_next.cycPulseCnt = '0;
          end
        end
        OFS_TMRSEL: st_next.timerSel = pwdata[3:0];
        OFS_ALARM: begin
          st_next.alarmMin  = pwdata[6:0];
          st_next.alarmHour = pwdata[POS_ALARM_HOUR +: 6];
        end
        default: ;
      endcase
    end

    // Busy ends once the oscillator runs and no carry is pending.
    if (st_reg.carryBusy && st_reg.oscSync && !carryActive
        && !(wrEn && paddr == OFS_CTRL3)) begin
      st_next.carryBusy = 1'b0;
    end

    // Chip enable low restarts time counting.
    if (!st_reg.ceSync) begin
      st_next.clockRun = 1'b1;
    end

    // Alarm flag is set on the match edge and wins over a flag-bit clear, but a disarm clears it.
    st_next.matchPrev = alarmMatch;
    if (alarmMatch && !st_reg.matchPrev) begin
      st_next.alarmFlag = 1'b1;
    end
    if (!st_next.alarmArm) begin
      st_next.alarmFlag = 1'b0;
    end

    // Cyclic request, independent of chip enable.
    if (st_reg.cycPulseCnt != '0) begin
      st_next.cycPulseCnt = st_reg.cycPulseCnt - PULSE_W'(1);
      if (st_reg.cycPulseCnt == PULSE_W'(1)) begin
        st_next.cyclicReq = 1'b0;
      end
    end
    if (cycPulse) begin
      st_next.cyclicReq = 1'b1;
      if (st_reg.cycleSel[BIT_SEL_MSB]) begin
        st_next.cycPulseCnt = '0;
      end else begin
        st_next.cycPulseCnt = PULSE_W'(PULSE_CYCLES);
      end
    end

    // Oscillator stop detection, set wins over the host clear.
    if (!st_reg.oscSync) begin
      st_next.oscStopFlag = 1'b1;
      st_next.timerSel[BIT_SEL_MSB] = 1'b0;
    end

    // Timer output pulse.
    if (st_reg.tmrPulseCnt != '0) begin
      st_next.tmrPulseCnt = st_reg.tmrPulseCnt - PULSE_W'(1);
    end
    if (tmrPulse && st_reg.timerSel[BIT_SEL_MSB]) begin
      st_next.tmrPulseCnt = PULSE_W'(PULSE_CYCLES);
    end
    if (timerRestart || !st_next.timerSel[BIT_SEL_MSB]) begin
      st_next.tmrPulseCnt = '0;
    end
    st_next.timerOut = st_next.tmrPulseCnt != '0;

    // Pin drive follows the two sources.
    st_next.irqPending = st_next.alarmFlag || st_next.cyclicReq;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg             <= '0;
      st_reg.clockRun    <= RST_CLOCK_RUN;
      st_reg.oscStopFlag <= RST_OSC_STOP;
      st_reg.cycleSel    <= RST_SEL;
      st_reg.timerSel    <= RST_SEL;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Period counters
  // ----------------------------------------------------------------
  // Reprogramming the cycle restarts its count, so the first period
  // after a write is always whole.
  rtc_period_cnt #(
    .W (PER_W)
  ) u_cyc_cnt (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick    (oscTick),
    .run     (1'b1),
    .restart (cycRestart),
    .period  (cycPeriod),
    .pulse   (cycPulse)
  );

  rtc_period_cnt #(
    .W (PER_W)
  ) u_tmr_cnt (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick    (oscTick),
    .run     (st_reg.ceSync),
    .restart (timerRestart),
    .period  (tmrPeriod),
    .pulse   (tmrPulse)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata            = st_reg.prdata;
  assign pslverr           = st_reg.slvErr;
  assign pready            = 1'b1;
  assign clockRun          = st_reg.clockRun;
  assign irqOutNOut        = 1'b0;
  assign irqOutNOe         = st_reg.irqPending;
  assign periodicPulseOutN = !st_reg.timerOut;

endmodule

//--- test/rtc_event_props.sv
// Purpose: Port-level property checks of the clock event core.
// Assumes: Chip enable stays high around register accesses.
// Notes:   Two-flop input syncs are covered by repetition margins.
`timescale 1ns/1ns
module rtc_event_props
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Register bus
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and time counter side
  input wire logic        chipEnable,
  input wire logic        oscAlive,
  input wire logic        oscTick,
  input wire logic        carryActive,
  input wire logic [6:0]  curMinute,
  input wire logic [5:0]  curHour,
  input wire logic        clockRun,
  input wire logic        irqOutNOut,
  input wire logic        irqOutNOe,
  input wire logic        periodicPulseOutN
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_flag_read;
    psel && penable && !pwrite && paddr == OFS_CTRL2;
  endsequence
  sequence s_bad_access;
    psel && penable && paddr > OFS_ALARM;
  endsequence

  a_pin_open_drain: assert property (irqOutNOut == 1'b0)
    else $error("interrupt pin data is not low");
  a_ready_const: assert property (pready == 1'b1)
    else $error("ready dropped");
  a_flags_vs_pin: assert property (s_flag_read |->
    (prdata[BIT_CYCLIC_FLAG] | prdata[BIT_ALARM_FLAG]) == $past(irqOutNOe))
    else $error("flag bits disagree with interrupt pin");
  a_bad_addr_err: assert property (s_bad_access |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  // Only a bus write may cut a request short, so quiet cycles must hold it.
  a_irq_min_hold: assert property ($rose(irqOutNOe) ##0
    (!(psel && pwrite))[*8] |-> irqOutNOe)
    else $error("interrupt pin released too early");
  a_ce_forces_run: assert property (!chipEnable[*4] |-> clockRun)
    else $error("clock run not forced with chip enable low");
  a_tmr_pulse_hold: assert property (
    $fell(periodicPulseOutN) ##0 (oscAlive && !(psel && pwrite))[*8]
    |-> !periodicPulseOutN)
    else $error("timer pulse too short");
  a_osc_stop_tmr: assert property (!oscAlive[*5] |-> periodicPulseOutN)
    else $error("timer pulse while oscillator stopped");
endmodule

bind rtc_event_core rtc_event_props rtc_event_props_inst (.*);

//--- test/rtc_osc_model.sv
// Purpose: Crystal side and interrupt wire model for the event core.
// Assumes: One oscillator tick every second clock cycle while alive.
// Notes:   The fast tick rate trades realism for a short run.
`timescale 1ns/1ns
module rtc_osc_model (
  // Clock and oscillator state
  input  wire logic ref_clk,
  input  wire logic oscAlive,
  // Tick strobe
  output      logic oscTick,
  // Interrupt wire
  input  wire logic irqOutNOe,
  output      logic irqLevel
);
  initial oscTick = 1'b0;
  // A stopped crystal delivers no ticks at all.
  always @(posedge ref_clk) oscTick <= oscAlive && !oscTick;
  // The pull-up holds the wire high whenever nobody sinks it.
  assign irqLevel = irqOutNOe ? 1'b0 : 1'b1;
endmodule

//--- test/rtc_interrupt_timer_osc_monitor_bench.sv
// Purpose: Register-level test of the clock event logic.
// Assumes: Chip enable is high for every register access.
// Notes:   Only the short cyclic periods are timed to bound run time.
`timescale 1ns/1ns
`define CHK(a, b) check(32'(a), 32'(b))
module rtc_interrupt_timer_osc_monitor_bench;
  import rtc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chipEnable = 1'b1;
  logic        oscAlive = 1'b0;
  logic        oscTick;
  logic        carryActive = 1'b1;
  logic [6:0]  curMinute = 7'h14;
  logic [5:0]  curHour = 6'h08;
  logic        clockRun;
  logic        irqOutNOe;
  logic        irqLevel;
  logic        periodicPulseOutN;
  logic [31:0] q;
  logic        slvErr;
  int          miscompares = 0;
  int          checks = 0;
  int          n;
  logic [20:0] per [4] = '{CYC_T_488US, CYC_T_977US, CYC_T_7MS, CYC_T_62MS};

  initial forever #20 ref_clk = !ref_clk;

  rtc_event_core rtc_event_core_inst (.*, .irqOutNOut());
  rtc_osc_model rtc_osc_model_inst (.*);

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 16) begin
      k++;
      @(posedge ref_clk);
    end
    if (k == 16) begin
      miscompares++;
      finish_test();
    end
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(q, exp);
  endtask

  // Counts cycles until the chosen pin reaches lvl; stops at lim.
  task automatic wait_pin(input bit tmr, input logic lvl, input int lim);
    n = 0;
    while ((tmr ? periodicPulseOutN : irqLevel) !== lvl && n < lim) begin
      n++;
      @(posedge ref_clk);
    end
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    // Chip enable needs two edges through its sync before the bus works.
    repeat (2) @(posedge ref_clk);
    rd(OFS_CTRL2, 32'hC);
    carryActive <= 1'b0;
    apb(1'b1, OFS_CTRL3, 32'h7);
    rd(OFS_CTRL2, 32'hC);
    apb(1'b1, OFS_CTRL1, 32'hC);
    rd(OFS_CTRL1, 32'h8);
    `CHK(clockRun, 1'b0);
    oscAlive <= 1'b1;
    q = 32'h4;
    for (int i = 0; i < 50 && q[BIT_CARRY_BUSY] !== 1'b0; i++)
      apb(1'b0, OFS_CTRL2, 32'h0);
    rd(OFS_CTRL2, 32'h8);
    apb(1'b1, OFS_CTRL2, 32'h0);
    rd(OFS_CTRL2, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    `CHK({q, slvErr}, 33'h1);
    // Pulse mode ends by itself after a fixed width.
    // The period must outlast the pulse, or each pulse restarts the next.
    apb(1'b1, OFS_CYCSEL, 32'h4);
    wait_pin(0, 1'b0, 5000);
    `CHK(n < 5000, 1);
    rd(OFS_CTRL2, 32'h1);
    wait_pin(0, 1'b1, 1000);
    `CHK(n < 1000, 1);
    `CHK(n + 8 >= PULSE_CYCLES && n <= PULSE_CYCLES, 1);
    // Level mode: time each period, then clear by writing zero.
    foreach (per[i]) begin
      apb(1'b1, OFS_CYCSEL, 32'(8 + i + 1));
      wait_pin(0, 1'b0, 5000);
      `CHK(n >= 2 * per[i] - 4 && n <= 2 * per[i] + 8, 1);
      apb(1'b1, OFS_CTRL2, 32'h0);
      repeat (3) @(posedge ref_clk);
      `CHK(irqLevel, 1'b1);
    end
    apb(1'b1, OFS_CYCSEL, 32'h0);
    apb(1'b1, OFS_CTRL2, 32'h0);
    wait_pin(0, 1'b0, 600);
    `CHK(n, 600);
    // Alarm: disarm, load time, arm, then match with chip enable low.
    apb(1'b1, OFS_CTRL1, 32'h0);
    apb(1'b1, OFS_ALARM, {18'h0, 6'h08, 1'b0, 7'h15});
    apb(1'b1, OFS_CTRL1, 32'h2);
    chipEnable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    curMinute <= 7'h15;
    wait_pin(0, 1'b0, 20);
    `CHK(n < 20, 1);
    `CHK(clockRun, 1'b1);
    chipEnable <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(OFS_CTRL2, 32'h2);
    apb(1'b1, OFS_CTRL1, 32'h1);
    repeat (3) @(posedge ref_clk);
    `CHK(irqLevel, 1'b1);
    // Timer: pulse, restart mid-pulse, halt with chip enable low.
    apb(1'b1, OFS_TMRSEL, 32'h8);
    wait_pin(1, 1'b0, 100);
    `CHK(n < 100, 1);
    repeat (20) @(posedge ref_clk);
    apb(1'b1, OFS_CTRL1, 32'h5);
    repeat (2) @(posedge ref_clk);
    `CHK(periodicPulseOutN, 1'b1);
    chipEnable <= 1'b0;
    wait_pin(1, 1'b0, 200);
    `CHK(n, 200);
    chipEnable <= 1'b1;
    wait_pin(1, 1'b0, 100);
    `CHK(n < 100, 1);
    oscAlive <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(OFS_TMRSEL, 32'h0);
    rd(OFS_CTRL2, 32'h8);
    finish_test();
  end
endmodule
